// ===== core/cbt_top.sv
// CAN bit timing and initialization control with Avalon-MM register slave
`timescale 1ns/1ps
// Summary of operation
// - Resync lengthens segment one or shortens segment two by at most jump width
// - Bit rate is clock over prescaler field plus one times quanta per bit
// - Quanta per bit: segment one plus one, segment two plus one, one sync
// - Every stored timing field is used as its raw value plus one
// - Protected control bits and registers change only while unlocked
// - Reset leaves change request and change enabled status both set
// - Software requests configuration; status sets once initialization mode entered
// - A zero segment field keeps initialization mode and status set
// - Pin control value eight routes pins to CAN transmit and receive
// - Status clears once initialization is left and block is configured
// - Mode changes only after eleven recessive bits; stuck dominant blocks it
module cbt_top (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  input  wire logic [5:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_can_rx,
  input  wire logic        i_tx_bit,
  output logic             o_can_tx,
  output logic             o_tq_tick,
  output logic             o_bit_sample,
  output logic             o_rx_bit
);

  cbt_pkg::cbt_mode_e   mode_reg;
  cbt_pkg::cbt_mode_e   mode_next;
  cbt_pkg::cbt_timing_s timing_w;

  logic [15:0] mc_reg;
  logic [31:0] btc_reg;
  logic [31:0] gim_reg;
  logic [31:0] mbim_reg;
  logic [31:0] tstamp_reg;
  logic [3:0]  tioc_reg;
  logic [3:0]  rioc_reg;
  logic        unlk_reg;
  logic [3:0]  idle_cnt_reg;

  logic        req_w;
  logic        wr_w;
  logic        hit_mc;
  logic        hit_btc;
  logic        hit_es;
  logic        hit_gim;
  logic        hit_mbim;
  logic        hit_tstamp;
  logic        hit_tioc;
  logic        hit_rioc;
  logic        hit_unlk;
  logic [31:0] mc_w;
  logic [31:0] btc_w;
  logic [31:0] gim_w;
  logic [31:0] mbim_w;
  logic [31:0] tstamp_w;
  logic [31:0] tioc_w;
  logic [31:0] rioc_w;
  logic [31:0] unlk_w;
  logic [31:0] rd_w;
  logic        chg_req_w;
  logic        chg_en_w;
  logic        seg_zero;
  logic        idle_w;
  logic        tx_fn_w;
  logic        rx_fn_w;
  logic        can_rx_w;

  // Address decode
  assign req_w    = i_avs_read || i_avs_write;
  assign wr_w     = i_avs_write && !o_avs_waitrequest;
  assign hit_mc   = i_avs_address == cbt_pkg::OFS_MC;
  assign hit_btc  = i_avs_address == cbt_pkg::OFS_BTC;
  assign hit_es   = i_avs_address == cbt_pkg::OFS_ES;
  assign hit_gim  = i_avs_address == cbt_pkg::OFS_GIM;
  assign hit_mbim   = i_avs_address == cbt_pkg::OFS_MBIM;
  assign hit_tstamp = i_avs_address == cbt_pkg::OFS_TSTAMP;
  assign hit_tioc = i_avs_address == cbt_pkg::OFS_TIOC;
  assign hit_rioc = i_avs_address == cbt_pkg::OFS_RIOC;
  assign hit_unlk = i_avs_address == cbt_pkg::OFS_UNLK;

  // Write values after byte lanes and protection
  assign mc_w = cbt_pkg::wr_merge({16'h0000, mc_reg}, i_avs_writedata,
                                  i_avs_byteenable, cbt_pkg::MC_PROT, unlk_reg);
  assign btc_w = cbt_pkg::wr_merge(btc_reg, i_avs_writedata,
                                   i_avs_byteenable, cbt_pkg::ALL_PROT, unlk_reg);
  assign gim_w = cbt_pkg::wr_merge(gim_reg, i_avs_writedata,
                                   i_avs_byteenable, cbt_pkg::ALL_PROT, unlk_reg);
  assign mbim_w = cbt_pkg::wr_merge(mbim_reg, i_avs_writedata,
                                    i_avs_byteenable, cbt_pkg::ALL_PROT, unlk_reg);
  assign tstamp_w = cbt_pkg::wr_merge(tstamp_reg, i_avs_writedata,
                                   i_avs_byteenable, cbt_pkg::ALL_PROT, unlk_reg);
  assign tioc_w = cbt_pkg::wr_merge({28'h0000000, tioc_reg}, i_avs_writedata,
                                    i_avs_byteenable, cbt_pkg::IOC_PROT, unlk_reg);
  assign rioc_w = cbt_pkg::wr_merge({28'h0000000, rioc_reg}, i_avs_writedata,
                                    i_avs_byteenable, cbt_pkg::IOC_PROT, unlk_reg);
  assign unlk_w = cbt_pkg::wr_merge({31'h00000000, unlk_reg}, i_avs_writedata,
                                    i_avs_byteenable, cbt_pkg::NO_PROT, 1'b1);

  // Status and pin routing
  assign timing_w = cbt_pkg::timing_of(btc_reg);
  assign chg_req_w = mc_reg[cbt_pkg::MC_CHG_REQ];
  assign chg_en_w  = mode_reg == cbt_pkg::CBT_INIT;
  assign seg_zero  = timing_w.seg1 == 4'h0 || timing_w.seg2 == 3'h0;
  assign idle_w   = idle_cnt_reg == cbt_pkg::IDLE_BITS;
  assign tx_fn_w  = tioc_reg == cbt_pkg::IOC_CAN_FN;
  assign rx_fn_w  = rioc_reg == cbt_pkg::IOC_CAN_FN;
  // A pin not yet routed reads recessive so it cannot fake activity
  assign can_rx_w = rx_fn_w ? i_can_rx : 1'b1;

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_w = 32'h0000_0000;
    if (hit_mc) begin
      rd_w = {16'h0000, mc_reg};
    end else if (hit_btc) begin
      rd_w = btc_reg;
    end else if (hit_es) begin
      rd_w[cbt_pkg::ES_CHG_EN] = chg_en_w;
      rd_w[cbt_pkg::ES_IDLE] = idle_w;
    end else if (hit_gim) begin
      rd_w = gim_reg;
    end else if (hit_mbim) begin
      rd_w = mbim_reg;
    end else if (hit_tstamp) begin
      rd_w = tstamp_reg;
    end else if (hit_tioc) begin
      rd_w = {28'h0000000, tioc_reg};
    end else if (hit_rioc) begin
      rd_w = {28'h0000000, rioc_reg};
    end else if (hit_unlk) begin
      rd_w = {31'h00000000, unlk_reg};
    end
  end

  // Mode transitions wait for a quiet bus
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      cbt_pkg::CBT_INIT: begin
        if (!chg_req_w && !seg_zero && idle_w) begin
          mode_next = cbt_pkg::CBT_NORMAL;
        end
      end
      default: begin
        if (chg_req_w && idle_w) begin
          mode_next = cbt_pkg::CBT_INIT;
        end
      end
    endcase
  end

  // One wait state per access keeps read data registered
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h0000_0000;
    end else begin
      o_avs_waitrequest <= !(req_w && o_avs_waitrequest);
      if (i_avs_read && o_avs_waitrequest) begin
        o_avs_readdata <= rd_w;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      mc_reg <= cbt_pkg::MC_RST;
    end else if (wr_w && hit_mc) begin
      mc_reg <= mc_w[15:0];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      btc_reg <= cbt_pkg::BTC_RST;
    end else if (wr_w && hit_btc) begin
      btc_reg <= btc_w & cbt_pkg::BTC_MASK;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      gim_reg <= 32'h0000_0000;
      mbim_reg   <= 32'h0000_0000;
      tstamp_reg <= 32'h0000_0000;
    end else if (wr_w) begin
      if (hit_gim) gim_reg <= gim_w;
      if (hit_mbim) mbim_reg <= mbim_w;
      if (hit_tstamp) tstamp_reg <= tstamp_w;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      tioc_reg <= 4'h0;
      rioc_reg <= 4'h0;
    end else if (wr_w) begin
      if (hit_tioc) tioc_reg <= tioc_w[3:0];
      if (hit_rioc) rioc_reg <= rioc_w[3:0];
    end
  end

  // Unlock is itself never protected, or it could not be opened
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      unlk_reg <= 1'b0;
    end else if (wr_w && hit_unlk) begin
      unlk_reg <= unlk_w[0];
    end
  end

  // Recessive sample points counted, saturating at eleven
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      idle_cnt_reg <= 4'h0;
    end else if (o_bit_sample) begin
      if (!o_rx_bit) begin
        idle_cnt_reg <= 4'h0;
      end else if (!idle_w) begin
        idle_cnt_reg <= idle_cnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      mode_reg <= cbt_pkg::CBT_INIT;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Initialization mode sends recessive only
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_can_tx <= 1'b1;
    end else begin
      o_can_tx <= tx_fn_w ? (chg_en_w | i_tx_bit) : 1'b1;
    end
  end

  cbt_bit_timer u_bit_timer (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_timing  (timing_w),
    .i_rx      (can_rx_w),
    .o_tq_tick (o_tq_tick),
    .o_sample  (o_bit_sample),
    .o_rx_bit  (o_rx_bit)
  );

  sequence s_locked_btc;
    wr_w && hit_btc && !unlk_reg;
  endsequence

  sequence s_locked_mc;
    wr_w && hit_mc && !unlk_reg;
  endsequence

  sequence s_leave_init;
    mode_reg == cbt_pkg::CBT_INIT ##1 mode_reg == cbt_pkg::CBT_NORMAL;
  endsequence

  property p_reset_state;
    @(posedge i_sys_clk) disable iff (i_reset)
      $past(i_reset) |-> chg_req_w && chg_en_w;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("request and enabled status not set after reset");

  property p_btc_locked;
    @(posedge i_sys_clk) disable iff (i_reset)
      s_locked_btc |=> $stable(btc_reg);
  endproperty
  a_btc_locked: assert property (p_btc_locked)
    else $error("timing register changed while locked");

  property p_mc_locked;
    @(posedge i_sys_clk) disable iff (i_reset)
      s_locked_mc |=> ((mc_reg ^ $past(mc_reg)) & cbt_pkg::MC_PROT[15:0]) == 16'h0000;
  endproperty
  a_mc_locked: assert property (p_mc_locked)
    else $error("protected control bit changed while locked");

  property p_stay_init;
    @(posedge i_sys_clk) disable iff (i_reset)
      (seg_zero && chg_en_w) |=> chg_en_w;
  endproperty
  a_stay_init: assert property (p_stay_init)
    else $error("left initialization with a zero segment");

  property p_enter_init;
    @(posedge i_sys_clk) disable iff (i_reset)
      (!chg_en_w && chg_req_w && idle_w) |=> chg_en_w;
  endproperty
  a_enter_init: assert property (p_enter_init)
    else $error("status not set after request on idle bus");

  property p_leave_init;
    @(posedge i_sys_clk) disable iff (i_reset)
      s_leave_init |-> $past(idle_w) && !$past(chg_req_w) && !$past(seg_zero);
  endproperty
  a_leave_init: assert property (p_leave_init)
    else $error("left initialization without idle or with request set");

  property p_idle_switch;
    @(posedge i_sys_clk) disable iff (i_reset)
      $changed(mode_reg) |-> $past(idle_cnt_reg) == cbt_pkg::IDLE_BITS;
  endproperty
  a_idle_switch: assert property (p_idle_switch)
    else $error("mode switched before eleven recessive bits");

  property p_pin_idle;
    @(posedge i_sys_clk) disable iff (i_reset)
      (!tx_fn_w || chg_en_w) |=> o_can_tx;
  endproperty
  a_pin_idle: assert property (p_pin_idle)
    else $error("transmit pin dominant while not routed or in init");

  property p_bus_answer;
    @(posedge i_sys_clk) disable iff (i_reset)
      (req_w && o_avs_waitrequest) |=> !o_avs_waitrequest ##1 o_avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer not given after one wait state");
endmodule

// ===== common/cbt_pkg.sv
// CAN bit timing and init control: shared constants, types and helpers
package cbt_pkg;
  localparam logic [5:0] OFS_MC   = 6'h00;
  localparam logic [5:0] OFS_BTC  = 6'h04;
  localparam logic [5:0] OFS_ES   = 6'h08;
  localparam logic [5:0] OFS_GIM  = 6'h0c;
  localparam logic [5:0] OFS_MBIM   = 6'h10;
  localparam logic [5:0] OFS_TSTAMP = 6'h14;
  localparam logic [5:0] OFS_TIOC = 6'h18;
  localparam logic [5:0] OFS_RIOC = 6'h1c;
  localparam logic [5:0] OFS_UNLK = 6'h20;

  localparam int MC_CHG_REQ = 12;
  localparam int ES_IDLE    = 0;
  localparam int ES_CHG_EN  = 4;
  localparam int BTC_PRESC  = 16;
  localparam int BTC_JUMP   = 8;
  localparam int BTC_SEG1   = 3;
  localparam int BTC_SEG2   = 0;

  localparam logic [15:0] MC_RST    = 16'h1000;
  localparam logic [31:0] BTC_RST   = 32'h0000_0000;
  localparam logic [31:0] BTC_MASK  = 32'h00ff_037f;
  localparam logic [31:0] MC_PROT   = 32'h0000_fec0;
  localparam logic [31:0] ALL_PROT  = 32'hffff_ffff;
  localparam logic [31:0] NO_PROT   = 32'h0000_0000;
  localparam logic [31:0] IOC_PROT  = 32'h0000_0008;
  localparam logic [3:0]  IOC_CAN_FN = 4'h8;
  localparam logic [3:0]  IDLE_BITS  = 4'hb;

  typedef struct packed {
    logic [7:0] presc;
    logic [1:0] jump;
    logic [3:0] seg1;
    logic [2:0] seg2;
  } cbt_timing_s;

  typedef enum logic [1:0] {CBT_INIT, CBT_NORMAL} cbt_mode_e;
  typedef enum logic [1:0] {PH_SYNC, PH_SEG1, PH_SEG2} cbt_phase_e;

  function automatic logic [8:0] plus_one(input logic [7:0] v);
    return {1'b0, v} + 9'h001;
  endfunction

  function automatic logic [4:0] bit_quanta(input cbt_timing_s t);
    return 5'(plus_one({4'h0, t.seg1}) + plus_one({5'h00, t.seg2}) + 9'h001);
  endfunction

  function automatic cbt_timing_s timing_of(input logic [31:0] b);
    cbt_timing_s t;
    t.presc = b[BTC_PRESC +: 8];
    t.jump  = b[BTC_JUMP +: 2];
    t.seg1  = b[BTC_SEG1 +: 4];
    t.seg2  = b[BTC_SEG2 +: 3];
    return t;
  endfunction

  function automatic logic [31:0] wr_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be, input logic [31:0] prot,
                                           input logic unlk);
    logic [31:0] m;
    for (int i = 0; i < 4; i++) m[8*i +: 8] = be[i] ? wd[8*i +: 8] : old[8*i +: 8];
    return unlk ? m : ((old & prot) | (m & ~prot));
  endfunction
endpackage

// ===== core/cbt_bit_timer.sv
// CAN bit timer: quantum prescaler, segment sequencer and resynchronisation
`timescale 1ns/1ps
module cbt_bit_timer (
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_reset,
  input  wire cbt_pkg::cbt_timing_s i_timing,
  input  wire logic                 i_rx,
  output logic                      o_tq_tick,
  output logic                      o_sample,
  output logic                      o_rx_bit
);
  cbt_pkg::cbt_phase_e  phase_reg;
  cbt_pkg::cbt_timing_s t_q_reg;
  logic [7:0] presc_reg;
  logic [4:0] q_reg, bq_reg;
  logic [2:0] ext_reg, shrink_reg;
  logic       rx_prev_reg, resynced_reg, gap_ok_reg, bq_ok_reg;
  logic [8:0] gap_reg;
  logic       tick_w, edge_w, end1_w, end2_w, restart_w, chg_w;
  logic [2:0] jump_len, ext_calc;
  logic [4:0] base1, base2, e1, len1, len2, rem2;

  assign tick_w    = presc_reg == i_timing.presc;
  assign jump_len  = 3'(cbt_pkg::plus_one({6'h00, i_timing.jump}));
  assign base1     = 5'(cbt_pkg::plus_one({4'h0, i_timing.seg1}));
  assign base2     = 5'(cbt_pkg::plus_one({5'h00, i_timing.seg2}));
  assign edge_w    = tick_w && rx_prev_reg && !i_rx && !resynced_reg;
  assign e1        = q_reg + 5'h01;
  assign ext_calc  = (e1 > {2'b00, jump_len}) ? jump_len : e1[2:0];
  assign len1      = base1 + {2'b00, (edge_w ? ext_calc : ext_reg)};
  assign rem2      = base2 - q_reg - {2'b00, shrink_reg};
  assign restart_w = edge_w && phase_reg == cbt_pkg::PH_SEG2 && rem2 <= {2'b00, jump_len};
  assign len2      = base2 - {2'b00, (edge_w ? jump_len : shrink_reg)};
  assign end1_w    = q_reg == len1 - 5'h01;
  assign end2_w    = q_reg == len2 - 5'h01;
  assign chg_w     = i_timing != t_q_reg;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      presc_reg <= 8'h00;
      o_tq_tick <= 1'b0;
      o_sample  <= 1'b0;
    end else begin
      presc_reg <= tick_w ? 8'h00 : presc_reg + 8'h01;
      o_tq_tick <= tick_w;
      o_sample  <= tick_w && phase_reg == cbt_pkg::PH_SEG1 && end1_w;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      phase_reg    <= cbt_pkg::PH_SYNC;
      q_reg        <= 5'h00;
      ext_reg      <= 3'h0;
      shrink_reg   <= 3'h0;
      rx_prev_reg  <= 1'b1;
      resynced_reg <= 1'b0;
      o_rx_bit     <= 1'b1;
    end else if (tick_w) begin
      rx_prev_reg <= i_rx;
      case (phase_reg)
        cbt_pkg::PH_SYNC: begin
          phase_reg    <= cbt_pkg::PH_SEG1;
          q_reg        <= 5'h00;
          ext_reg      <= 3'h0;
          shrink_reg   <= 3'h0;
          resynced_reg <= 1'b0;
        end
        cbt_pkg::PH_SEG1: begin
          if (edge_w) begin
            ext_reg      <= ext_calc;
            resynced_reg <= 1'b1;
          end
          if (end1_w) begin
            phase_reg <= cbt_pkg::PH_SEG2;
            q_reg     <= 5'h00;
            o_rx_bit  <= i_rx;
          end else begin
            q_reg <= q_reg + 5'h01;
          end
        end
        default: begin
          if (restart_w) begin
            phase_reg    <= cbt_pkg::PH_SEG1;
            q_reg        <= 5'h00;
            ext_reg      <= 3'h0;
            shrink_reg   <= 3'h0;
            resynced_reg <= 1'b0;
          end else begin
            if (edge_w) begin
              shrink_reg   <= jump_len;
              resynced_reg <= 1'b1;
            end
            phase_reg <= end2_w ? cbt_pkg::PH_SYNC : cbt_pkg::PH_SEG2;
            q_reg     <= end2_w ? 5'h00 : q_reg + 5'h01;
          end
        end
      endcase
    end
  end

  // Check helpers; a timing change voids the running measurement
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      t_q_reg    <= '0;
      gap_reg    <= 9'h000;
      gap_ok_reg <= 1'b0;
      bq_reg     <= 5'h00;
      bq_ok_reg  <= 1'b0;
    end else begin
      t_q_reg    <= i_timing;
      gap_reg    <= tick_w ? 9'h000 : gap_reg + 9'h001;
      gap_ok_reg <= chg_w ? 1'b0 : (tick_w ? 1'b1 : gap_ok_reg);
      if (tick_w) bq_reg <= (phase_reg == cbt_pkg::PH_SYNC || restart_w) ? 5'h01 : bq_reg + 5'h01;
      bq_ok_reg  <= chg_w ? 1'b0 : ((tick_w && phase_reg == cbt_pkg::PH_SYNC) ? 1'b1 : bq_ok_reg);
    end
  end

  property p_tq_div;
    @(posedge i_sys_clk) disable iff (i_reset)
      (tick_w && gap_ok_reg) |-> gap_reg == {1'b0, i_timing.presc};
  endproperty
  a_tq_div: assert property (p_tq_div)
    else $error("quantum period differs from prescaler plus one");

  property p_bit_quanta;
    @(posedge i_sys_clk) disable iff (i_reset)
      (tick_w && phase_reg == cbt_pkg::PH_SYNC && !resynced_reg && bq_ok_reg && !chg_w)
        |-> bq_reg == cbt_pkg::bit_quanta(i_timing);
  endproperty
  a_bit_quanta: assert property (p_bit_quanta)
    else $error("unsynchronised bit length is wrong");

  property p_jump;
    @(posedge i_sys_clk) disable iff (i_reset)
      (tick_w && !chg_w) |-> (ext_reg <= jump_len) && (shrink_reg <= jump_len);
  endproperty
  a_jump: assert property (p_jump)
    else $error("resync adjustment exceeds jump width");
endmodule

// ===== verif/cbt_bus_node.sv
// Behavioural CAN bus and transceiver seen from the device pins
`timescale 1ns/1ps
module cbt_bus_node (
  input  wire logic i_sys_clk,
  input  wire logic i_node_tx,
  input  wire logic i_hold_dominant,
  output logic      o_bus_rx
);
  // Wired-AND bus with pull-up: idle is recessive, any dominant driver wins
  // Registered to model transceiver loop delay, so no zero-delay feedback
  always_ff @(posedge i_sys_clk) begin
    o_bus_rx <= i_node_tx & ~i_hold_dominant;
  end
endmodule

// ===== verif/tb_can_bit_timing_init_control.sv
// Self-checking bench for the CAN bit timing and init control block
`timescale 1ns/1ps
module tb_can_bit_timing_init_control;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        can_rx;
  logic        tx_bit = 1'b1;
  logic        can_tx;
  logic        tq_tick;
  logic        bit_sample;
  logic        rx_bit;
  logic        hold_dominant = 1'b0;
  int          fails = 0;
  int          checks = 0;
  int          cyc = 0;

  always #2 sys_clk = ~sys_clk;

  cbt_top u_dut (
    .i_sys_clk        (sys_clk),
    .i_reset          (reset),
    .i_avs_address    (avs_address),
    .i_avs_read       (avs_read),
    .i_avs_write      (avs_write),
    .i_avs_writedata  (avs_writedata),
    .i_avs_byteenable (avs_byteenable),
    .o_avs_readdata   (avs_readdata),
    .o_avs_waitrequest(avs_waitrequest),
    .i_can_rx         (can_rx),
    .i_tx_bit         (tx_bit),
    .o_can_tx         (can_tx),
    .o_tq_tick        (tq_tick),
    .o_bit_sample     (bit_sample),
    .o_rx_bit         (rx_bit)
  );

  cbt_bus_node u_bus (
    .i_sys_clk      (sys_clk),
    .i_node_tx      (can_tx),
    .i_hold_dominant(hold_dominant),
    .o_bus_rx       (can_rx)
  );

  task automatic wrap_up();
    $display("checks %0d, fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Hang guard: whole run needs well under two thousand cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Entered just after an edge; request held until waitrequest is seen low
  task automatic acc(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask

  task automatic chk_reg(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    check(q & m, e);
  endtask

  task automatic wait_cce(input logic want, output int n);
    logic [31:0] q;
    n = 0;
    do begin
      acc(1'b0, cbt_pkg::OFS_ES, 32'h0, q);
      n += 3;
    end while (q[cbt_pkg::ES_CHG_EN] !== want && n < 900);
  endtask

  task automatic period(input logic sel, output int p);
    p = 0;
    do @(posedge sys_clk); while ((sel ? bit_sample : tq_tick) !== 1'b1);
    do begin
      @(posedge sys_clk);
      p++;
    end while ((sel ? bit_sample : tq_tick) !== 1'b1 && p < 200);
  endtask

  task automatic t_reset();
    chk_reg(cbt_pkg::OFS_MC, 32'hffff_ffff, 32'h0000_1000);
    chk_reg(cbt_pkg::OFS_ES, 32'h0000_0010, 32'h0000_0010);
    chk_reg(cbt_pkg::OFS_BTC, 32'hffff_ffff, 32'h0);
    chk_reg(6'h24, 32'hffff_ffff, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_protect();
    logic [5:0] ofs[3];
    ofs = '{cbt_pkg::OFS_GIM, cbt_pkg::OFS_MBIM, cbt_pkg::OFS_TSTAMP};
    wr(cbt_pkg::OFS_BTC, 32'hffff_ffff);
    chk_reg(cbt_pkg::OFS_BTC, 32'hffff_ffff, 32'h0);
    // Open bits must still land while locked, the protected ones must not
    wr(cbt_pkg::OFS_MC, 32'h0000_013f);
    chk_reg(cbt_pkg::OFS_MC, 32'hffff_ffff, 32'h0000_113f);
    wr(cbt_pkg::OFS_TIOC, 32'hf);
    chk_reg(cbt_pkg::OFS_TIOC, 32'hf, 32'h7);
    foreach (ofs[i]) begin
      wr(ofs[i], 32'h5a5a_c3c3);
      chk_reg(ofs[i], 32'hffff_ffff, 32'h0);
    end
    wr(cbt_pkg::OFS_UNLK, 32'h1);
    foreach (ofs[i]) begin
      wr(ofs[i], 32'h5a5a_c3c3);
      chk_reg(ofs[i], 32'hffff_ffff, 32'h5a5a_c3c3);
    end
    wr(cbt_pkg::OFS_BTC, 32'hffff_ffff);
    chk_reg(cbt_pkg::OFS_BTC, 32'hffff_ffff, 32'h00ff_037f);
    $display("test protect done");
  endtask

  // Second segment zero on an idle bus: must stay in initialization
  // Bus held dominant too; the unrouted receive pin must not see it
  task automatic t_zero_seg();
    hold_dominant <= 1'b1;
    wr(cbt_pkg::OFS_BTC, 32'h0001_0018);
    wr(cbt_pkg::OFS_MC, 32'h0);
    repeat (400) @(posedge sys_clk);
    check(32'(rx_bit), 32'h1);
    chk_reg(cbt_pkg::OFS_ES, 32'h0000_0011, 32'h0000_0011);
    hold_dominant <= 1'b0;
    $display("test zero segment done");
  endtask

  // Prescaler 2, segments 4 and 3 quanta: 8 quanta, 16 clocks per bit
  task automatic t_config();
    int n;
    wr(cbt_pkg::OFS_TIOC, 32'h8);
    wr(cbt_pkg::OFS_RIOC, 32'h8);
    wr(cbt_pkg::OFS_MC, 32'h0000_1000);
    wr(cbt_pkg::OFS_BTC, 32'h0001_011a);
    // No mailbox storage here; the mask registers keep their values at this step
    wr(cbt_pkg::OFS_MC, 32'h0);
    wait_cce(1'b0, n);
    chk_reg(cbt_pkg::OFS_ES, 32'h0000_0011, 32'h0000_0001);
    period(1'b0, n);
    check(n, 2);
    period(1'b1, n);
    check(n, 16);
    $display("test config done");
  endtask

  task automatic t_route();
    tx_bit <= 1'b0;
    repeat (40) @(posedge sys_clk);
    check(32'(can_tx), 32'h0);
    check(32'(rx_bit), 32'h0);
    tx_bit <= 1'b1;
    repeat (40) @(posedge sys_clk);
    check(32'(rx_bit), 32'h1);
    $display("test route done");
  endtask

  task automatic t_stuck();
    int n;
    hold_dominant <= 1'b1;
    wr(cbt_pkg::OFS_MC, 32'h0000_1000);
    repeat (400) @(posedge sys_clk);
    chk_reg(cbt_pkg::OFS_ES, 32'h0000_0010, 32'h0);
    hold_dominant <= 1'b0;
    wait_cce(1'b1, n);
    // Eleven recessive samples at 16 clocks each, minus phase slack
    check(32'(n >= 150 && n < 900), 32'h1);
    $display("test stuck bus done");
  endtask

  initial begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_protect();
    t_zero_seg();
    t_config();
    t_route();
    t_stuck();
    wrap_up();
  end
endmodule
